/* File: hw/amte_top.sv */
/*
  motion and tap event engine: any, still and significant motion plus single
  and double tap, stepped once per accelerometer sample.
  assumes register values, the command strobe and samples come from logic on
  mclk_in; the command handshake and parameter byte registers sit outside.
*/
`timescale 1ns/100ps
module amte_top (
  input  wire logic        mclk_in,
  input  wire logic        rst_n_in,
  // parameter transfer
  input  wire logic [7:0]  param_byte_0_in,
  input  wire logic [7:0]  param_byte_1_in,
  input  wire logic [7:0]  param_byte_2_in,
  input  wire logic [7:0]  param_byte_3_in,
  input  wire logic [7:0]  param_byte_4_in,
  input  wire logic [7:0]  param_byte_5_in,
  input  wire logic [7:0]  param_byte_6_in,
  input  wire logic [7:0]  param_set_index_byte_in,
  input  wire logic        command_strobe_in,
  input  wire logic [7:0]  command_handshake_reg_in,
  // control registers
  input  wire logic [7:0]  feature_control_reg_in,
  input  wire logic [7:0]  sensor_enable_reg_in,
  input  wire logic [7:0]  pin_control_reg_in,
  input  wire logic        free_running_sampling_in,
  // samples
  input  wire logic        sample_ready_strobe_in,
  input  wire logic [15:0] accel_x_in,
  input  wire logic [15:0] accel_y_in,
  input  wire logic [15:0] accel_z_in,
  // tap parameters
  input  wire logic [7:0]  tap_alpha_in,
  input  wire logic [7:0]  tap_gamma_in,
  input  wire logic [15:0] peak_mag_limit_in,
  input  wire logic [15:0] quiet_limit_in,
  input  wire logic [7:0]  peak_window_a_in,
  input  wire logic [15:0] tap_quiet_window_in,
  input  wire logic [15:0] double_tap_window_in,
  // results
  output logic      [7:0]  event_status_reg_out,
  output logic      [7:0]  motion_axis_mode_byte_out,
  output logic             irq_pin_one_out,
  output logic             irq_pin_two_out,
  output logic             tap_single_out,
  output logic             tap_double_out
);
  typedef enum logic [1:0] {SIG_IDLE, SIG_WAIT, SIG_CONFIRM, SIG_HELD} amte_sig_state_t;

  // counts with the same 8-bit shape share one comparison
  function automatic logic window_met(input logic [7:0] cnt, input logic [7:0] win);
    window_met = (win == 8'h00) ? 1'b1 : (cnt >= win);
  endfunction

  // or / and over enabled axes; nothing enabled never qualifies
  function automatic logic axis_combine(input logic [2:0] hit, input logic [2:0] en,
                                        input logic all_sel);
    if (en == 3'b000) begin
      axis_combine = 1'b0;
    end else if (all_sel) begin
      axis_combine = ((hit & en) == en);
    end else begin
      axis_combine = |(hit & en);
    end
  endfunction

  // configuration state
  logic [7:0]  mode_q, mode_d;
  logic [7:0]  move_limit_q [3];
  logic [7:0]  move_limit_d [3];
  logic [7:0]  still_limit_q [3];
  logic [7:0]  still_limit_d [3];
  logic [7:0]  move_window_q, move_window_d;
  logic [7:0]  still_window_q, still_window_d;
  logic [15:0] sig_wait_window_q, sig_wait_window_d;
  logic [15:0] sig_confirm_window_q, sig_confirm_window_d;

  // detection state
  logic signed [15:0] prev_q [3];
  logic signed [15:0] prev_d [3];
  logic               prev_valid_q, prev_valid_d;
  logic [7:0]         move_cnt_q, move_cnt_d;
  logic [7:0]         still_cnt_q, still_cnt_d;
  logic               move_q, move_d;
  logic               still_q, still_d;
  amte_sig_state_t    sig_state_q, sig_state_d;
  logic [15:0]        sig_cnt_q, sig_cnt_d;
  logic               sig_q, sig_d;
  logic               irq_one_q, irq_one_d;
  logic               irq_two_q, irq_two_d;
  logic               tap_single_q, tap_double_q;

  logic signed [15:0] acc [3];
  logic               accel_on;
  logic               move_on, still_on, sig_on;

  amte_tap_if tap_bus ();

  assign acc[0] = accel_x_in;
  assign acc[1] = accel_y_in;
  assign acc[2] = accel_z_in;
  assign accel_on = sensor_enable_reg_in[amte_pkg::SE_ACCEL_ON] && free_running_sampling_in;
  assign move_on  = feature_control_reg_in[amte_pkg::FC_MOVE_EN] && accel_on;
  assign still_on = feature_control_reg_in[amte_pkg::FC_STILL_EN] && accel_on;
  assign sig_on   = feature_control_reg_in[amte_pkg::FC_SIG_EN] && move_on && still_on;

  assign tap_bus.sample_ready      = sample_ready_strobe_in;
  assign tap_bus.active            = accel_on;
  assign tap_bus.acc               = acc;
  assign tap_bus.alpha             = tap_alpha_in;
  assign tap_bus.gamma             = tap_gamma_in;
  assign tap_bus.peak_mag_limit    = peak_mag_limit_in;
  assign tap_bus.quiet_limit       = quiet_limit_in;
  assign tap_bus.peak_window_a     = peak_window_a_in;
  assign tap_bus.tap_quiet_window  = tap_quiet_window_in;
  assign tap_bus.double_tap_window = double_tap_window_in;

  amte_tap_engine u_tap (
    .mclk_in  (mclk_in),
    .rst_n_in (rst_n_in),
    .tap      (tap_bus.engine)
  );

  // parameter loading
  always_comb begin
    logic [3:0] set_idx;
    set_idx = param_set_index_byte_in[7:4];
    if (set_idx == 4'h0) begin
      set_idx = param_set_index_byte_in[3:0];
    end
    mode_d = mode_q;
    move_limit_d = move_limit_q;
    still_limit_d = still_limit_q;
    move_window_d = move_window_q;
    still_window_d = still_window_q;
    sig_wait_window_d = sig_wait_window_q;
    sig_confirm_window_d = sig_confirm_window_q;
    // no sensor interlock: the host keeps both sensors off
    if (command_strobe_in && command_handshake_reg_in == amte_pkg::CMD_CONFIGURE_MOTION) begin
      if (set_idx == amte_pkg::PARAM_SET_ONE) begin
        move_limit_d[0] = param_byte_0_in;
        move_limit_d[1] = param_byte_1_in;
        move_limit_d[2] = param_byte_2_in;
        still_limit_d[0] = param_byte_3_in;
        still_limit_d[1] = param_byte_4_in;
        still_limit_d[2] = param_byte_5_in;
        mode_d = param_byte_6_in;
      end else if (set_idx == amte_pkg::PARAM_SET_TWO) begin
        move_window_d = param_byte_0_in;
        still_window_d = param_byte_1_in;
        sig_wait_window_d = {param_byte_3_in, param_byte_2_in};
        sig_confirm_window_d = {param_byte_5_in, param_byte_4_in};
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      mode_q <= amte_pkg::MODE_RESET;
      move_limit_q <= '{default: amte_pkg::LIMIT_RESET};
      still_limit_q <= '{default: amte_pkg::LIMIT_RESET};
      move_window_q <= amte_pkg::WINDOW_RESET;
      still_window_q <= amte_pkg::WINDOW_RESET;
      sig_wait_window_q <= amte_pkg::SIG_RESET;
      sig_confirm_window_q <= amte_pkg::SIG_RESET;
    end else begin
      mode_q <= mode_d;
      move_limit_q <= move_limit_d;
      still_limit_q <= still_limit_d;
      move_window_q <= move_window_d;
      still_window_q <= still_window_d;
      sig_wait_window_q <= sig_wait_window_d;
      sig_confirm_window_q <= sig_confirm_window_d;
    end
  end

  // motion detection, one step per sample
  always_comb begin
    logic [16:0] slope_abs [3];
    logic [2:0]  move_hit, still_hit;
    logic        move_qual, still_qual, move_rise, step;
    logic signed [16:0] slope;
    slope_abs = '{default: '0};
    move_hit = '0;
    still_hit = '0;
    slope = '0;
    prev_d = prev_q;
    prev_valid_d = prev_valid_q;
    move_cnt_d = move_cnt_q;
    still_cnt_d = still_cnt_q;
    move_d = move_q;
    still_d = still_q;
    sig_state_d = sig_state_q;
    sig_cnt_d = sig_cnt_q;
    sig_d = sig_q;
    step = sample_ready_strobe_in && accel_on;
    for (int i = 0; i < 3; i++) begin
      slope = 17'(acc[i]) - 17'(prev_q[i]);
      slope_abs[i] = slope < 0 ? 17'(-slope) : 17'(slope);
      // limits carry 5 fraction bits, samples 10, so shift limits up
      move_hit[i] = slope_abs[i] > ({9'h0, move_limit_q[i]} << amte_pkg::LIMIT_SHIFT);
      still_hit[i] = slope_abs[i] < ({9'h0, still_limit_q[i]} << amte_pkg::LIMIT_SHIFT);
    end
    move_qual = prev_valid_q && axis_combine(move_hit,
                mode_q[amte_pkg::MD_MOVE_EN_LSB +: 3], mode_q[amte_pkg::MD_MOVE_COMBINE]);
    still_qual = prev_valid_q && axis_combine(still_hit,
                 mode_q[amte_pkg::MD_STILL_EN_LSB +: 3], mode_q[amte_pkg::MD_STILL_COMBINE]);
    move_rise = 1'b0;
    if (step) begin
      for (int i = 0; i < 3; i++) begin
        prev_d[i] = acc[i];
      end
      prev_valid_d = 1'b1;
      if (move_qual) begin
        move_cnt_d = (move_cnt_q == 8'hff) ? move_cnt_q : move_cnt_q + 8'h01;
      end else begin
        move_cnt_d = '0;
      end
      move_d = move_qual && window_met(move_cnt_d, move_window_q);
      move_rise = move_d && !move_q;
      if (still_qual) begin
        still_cnt_d = (still_cnt_q == 8'hff) ? still_cnt_q : still_cnt_q + 8'h01;
      end else begin
        still_cnt_d = '0;
      end
      still_d = still_qual && window_met(still_cnt_d, still_window_q);
      if (sig_cnt_q != 16'hffff) begin
        sig_cnt_d = sig_cnt_q + 16'h0001;
      end
      case (sig_state_q)
        SIG_IDLE: begin
          if (move_rise) begin
            sig_state_d = SIG_WAIT;
            sig_cnt_d = '0;
          end
        end
        SIG_WAIT: begin
          // moves during the wait are ignored
          if (sig_cnt_d >= sig_wait_window_q) begin
            sig_state_d = SIG_CONFIRM;
          end
        end
        SIG_CONFIRM: begin
          if (sig_cnt_d > sig_confirm_window_q) begin
            sig_state_d = SIG_IDLE;
          end else if (move_d) begin
            sig_state_d = SIG_HELD;
            sig_d = 1'b1;
          end
        end
        SIG_HELD: begin
          if (still_d) begin
            sig_state_d = SIG_IDLE;
            sig_d = 1'b0;
          end
        end
        default: sig_state_d = SIG_IDLE;
      endcase
    end
    if (!accel_on) begin
      prev_valid_d = 1'b0;
    end
    if (!move_on) begin
      move_cnt_d = '0;
      move_d = 1'b0;
    end
    if (!still_on) begin
      still_cnt_d = '0;
      still_d = 1'b0;
    end
    if (!sig_on) begin
      sig_state_d = SIG_IDLE;
      sig_cnt_d = '0;
      sig_d = 1'b0;
    end
  end

  // pins follow sample-stepped flags, so they stay sample aligned
  always_comb begin
    logic motion_evt;
    motion_evt = move_d || still_d || sig_d;
    irq_one_d = motion_evt && feature_control_reg_in[amte_pkg::FC_PIN_SELECT]
                && pin_control_reg_in[amte_pkg::PC_PIN_ONE_EN];
    irq_two_d = motion_evt && !feature_control_reg_in[amte_pkg::FC_PIN_SELECT]
                && pin_control_reg_in[amte_pkg::PC_PIN_TWO_EN];
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      prev_q <= '{default: '0};
      prev_valid_q <= 1'b0;
      move_cnt_q <= '0;
      still_cnt_q <= '0;
      move_q <= 1'b0;
      still_q <= 1'b0;
      sig_state_q <= SIG_IDLE;
      sig_cnt_q <= '0;
      sig_q <= 1'b0;
      irq_one_q <= 1'b0;
      irq_two_q <= 1'b0;
      tap_single_q <= 1'b0;
      tap_double_q <= 1'b0;
    end else begin
      prev_q <= prev_d;
      prev_valid_q <= prev_valid_d;
      move_cnt_q <= move_cnt_d;
      still_cnt_q <= still_cnt_d;
      move_q <= move_d;
      still_q <= still_d;
      sig_state_q <= sig_state_d;
      sig_cnt_q <= sig_cnt_d;
      sig_q <= sig_d;
      irq_one_q <= irq_one_d;
      irq_two_q <= irq_two_d;
      tap_single_q <= tap_bus.tap_single;
      tap_double_q <= tap_bus.tap_double;
    end
  end

  always_comb begin
    event_status_reg_out = 8'h00;
    event_status_reg_out[amte_pkg::ST_MOVE] = move_q;
    event_status_reg_out[amte_pkg::ST_STILL] = still_q;
    event_status_reg_out[amte_pkg::ST_SIG] = sig_q;
  end
  assign motion_axis_mode_byte_out = mode_q;
  assign irq_pin_one_out = irq_one_q;
  assign irq_pin_two_out = irq_two_q;
  assign tap_single_out = tap_single_q;
  assign tap_double_out = tap_double_q;
endmodule

/* File: hw/amte_pkg.sv */
/*
  constants of the motion and tap event engine: codes, bit positions, resets, scaling.
  assumes accelerometer samples are signed 16-bit with 10 fractional bits (1/1024 g).
*/
// What this block does
// - still combine: 0 any axis, 1 all axes
// - move combine: 0 any axis, 1 all axes
// - only enabled axes take part per detector
// - slope limits unsigned, five fraction bits, 1/32 g
// - still needs still_window consecutive quiet samples
// - move needs move_window consecutive busy samples
// - after first move, ignore moves for wait window
// - confirming move only within confirm window
// - mode byte layout: still bits high, move low
// - set one limits and mode, set two windows
// - feature bits 1..3 enable engines, need accel on
// - motion event routed to pin by bit 6
// - status bits 5,6,7 show move, still, significant
// - tap runs only in free running sampling
// - tap keeps running average, linear is difference
// - peak starts over limit, valid if quiet later
// - valid peak then quiet window gives first tap
// - second tap after quiet, before window, doubles
// - tap inside quiet window restarts, no event
// - no second tap in window gives single tap
// - slope is sample minus previous; move clears inside
// - still clears once slope leaves the band
// - significant needs both engines, held until still
// - double tap window counts from first peak
package amte_pkg;
  localparam logic [7:0] CMD_CONFIGURE_MOTION = 8'h0e;
  localparam logic [3:0] PARAM_SET_ONE        = 4'h1;
  localparam logic [3:0] PARAM_SET_TWO        = 4'h2;

  // feature_control_reg
  localparam int FC_MOVE_EN    = 1;
  localparam int FC_STILL_EN   = 2;
  localparam int FC_SIG_EN     = 3;
  localparam int FC_PIN_SELECT = 6;
  // pin_control_reg
  localparam int PC_PIN_ONE_EN = 3;
  localparam int PC_PIN_TWO_EN = 4;
  // sensor_enable_reg
  localparam int SE_ACCEL_ON   = 0;
  localparam int SE_GYRO_ON    = 1;
  // event_status_reg
  localparam int ST_MOVE       = 5;
  localparam int ST_STILL      = 6;
  localparam int ST_SIG        = 7;
  // motion_axis_mode_byte
  localparam int MD_STILL_COMBINE = 7;
  localparam int MD_STILL_EN_LSB  = 4;
  localparam int MD_MOVE_COMBINE  = 3;
  localparam int MD_MOVE_EN_LSB   = 0;

  localparam logic [7:0]  MODE_RESET   = 8'h00;
  localparam logic [7:0]  LIMIT_RESET  = 8'h00;
  localparam logic [7:0]  WINDOW_RESET = 8'h01;
  localparam logic [15:0] SIG_RESET    = 16'h0001;

  localparam int SAMPLE_W    = 16;
  localparam int LIMIT_SHIFT = 5;   // 10 sample fraction bits minus 5 limit fraction bits
  localparam int MAG_SHIFT   = 10;  // peak_mag_limit has 10 fraction bits
  localparam int RATIO_SHIFT = 7;   // alpha and gamma have 7 fraction bits
endpackage

/* File: hw/amte_tap_if.sv */
/*
  bundle between the event top and its tap engine.
  assumes both ends run on the same clock.
*/
`timescale 1ns/100ps
interface amte_tap_if;
  logic                                  sample_ready;
  logic                                  active;
  logic signed [amte_pkg::SAMPLE_W-1:0]  acc [3];
  logic [7:0]                            alpha;
  logic [7:0]                            gamma;
  logic [15:0]                           peak_mag_limit;
  logic [15:0]                           quiet_limit;
  logic [7:0]                            peak_window_a;
  logic [15:0]                           tap_quiet_window;
  logic [15:0]                           double_tap_window;
  logic                                  tap_single;
  logic                                  tap_double;

  modport source (output sample_ready, active, acc, alpha, gamma, peak_mag_limit,
                  quiet_limit, peak_window_a, tap_quiet_window, double_tap_window,
                  input tap_single, tap_double);
  modport engine (input sample_ready, active, acc, alpha, gamma, peak_mag_limit,
                  quiet_limit, peak_window_a, tap_quiet_window, double_tap_window,
                  output tap_single, tap_double);
endinterface

/* File: hw/amte_tap_engine.sv */
/*
  single and double tap detector, one step per accelerometer sample.
  assumes parameters are stable while active and samples come with sample_ready.
*/
`timescale 1ns/100ps
module amte_tap_engine (
  input  wire logic  mclk_in,
  input  wire logic  rst_n_in,
  amte_tap_if.engine tap
);
  typedef enum logic [2:0] {T_IDLE, T_PEAK1, T_QUIET1, T_WAIT2, T_PEAK2} amte_tap_state_t;

  amte_tap_state_t    state_q, state_d;
  logic signed [23:0] avg_q [3];
  logic signed [23:0] avg_d [3];
  logic [25:0]        mov_q, mov_d;
  logic [15:0]        win_q, win_d;
  logic [15:0]        dtap_q, dtap_d;
  logic               single_q, single_d;
  logic               double_q, double_d;

  assign tap.tap_single = single_q;
  assign tap.tap_double = double_q;

  always_comb begin
    logic signed [16:0] lin [3];
    logic signed [31:0] diff;
    logic [35:0]        sq_sum;
    logic [18:0]        mag;
    logic signed [31:0] mdiff;
    logic               step, peak, quiet;
    lin = '{default: '0};
    diff = '0;
    sq_sum = '0;
    mag = '0;
    mdiff = '0;
    state_d = state_q;
    avg_d = avg_q;
    mov_d = mov_q;
    win_d = win_q;
    dtap_d = dtap_q;
    single_d = 1'b0;
    double_d = 1'b0;
    step = tap.sample_ready && tap.active;
    for (int i = 0; i < 3; i++) begin
      lin[i] = 17'(tap.acc[i]) - 17'(avg_q[i] >>> amte_pkg::RATIO_SHIFT);
      sq_sum = sq_sum + 36'(34'(lin[i] * lin[i]));
      mag = mag + 19'(lin[i] < 0 ? -lin[i] : lin[i]);
      diff = (32'(tap.acc[i]) <<< amte_pkg::RATIO_SHIFT) - 32'(avg_q[i]);
      if (step) begin
        avg_d[i] = avg_q[i] + 24'((diff * $signed({24'h0, tap.alpha})) >>> amte_pkg::RATIO_SHIFT);
      end
    end
    mdiff = (32'(mag) <<< amte_pkg::RATIO_SHIFT) - $signed({6'h0, mov_q});
    if (step) begin
      mov_d = mov_q + 26'((mdiff * $signed({24'h0, tap.gamma})) >>> amte_pkg::RATIO_SHIFT);
    end
    peak = sq_sum > {10'h0, tap.peak_mag_limit, 10'h0};
    quiet = mov_q[25:amte_pkg::RATIO_SHIFT] < {3'h0, tap.quiet_limit};
    if (!tap.active) begin
      state_d = T_IDLE;
      win_d = '0;
      dtap_d = '0;
    end else if (step) begin
      win_d = win_q + 16'h0001;
      if (state_q != T_IDLE && dtap_q != 16'hffff) begin
        dtap_d = dtap_q + 16'h0001;
      end
      case (state_q)
        T_IDLE: begin
          if (peak) begin
            state_d = T_PEAK1;
            win_d = '0;
            dtap_d = '0;
          end
        end
        T_PEAK1: begin
          if (win_d >= {8'h0, tap.peak_window_a}) begin
            state_d = quiet ? T_QUIET1 : T_IDLE;
            win_d = '0;
          end
        end
        T_QUIET1: begin
          if (peak || !quiet) begin
            state_d = T_IDLE;
          end else if (win_d >= tap.tap_quiet_window) begin
            state_d = T_WAIT2;
          end
        end
        T_WAIT2: begin
          if (dtap_d >= tap.double_tap_window) begin
            single_d = 1'b1;
            state_d = T_IDLE;
          end else if (peak) begin
            state_d = T_PEAK2;
            win_d = '0;
          end
        end
        T_PEAK2: begin
          if (win_d >= {8'h0, tap.peak_window_a}) begin
            double_d = quiet;
            state_d = T_IDLE;
          end
        end
        default: state_d = T_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      state_q <= T_IDLE;
      avg_q <= '{default: '0};
      mov_q <= '0;
      win_q <= '0;
      dtap_q <= '0;
      single_q <= 1'b0;
      double_q <= 1'b0;
    end else begin
      state_q <= state_d;
      avg_q <= avg_d;
      mov_q <= mov_d;
      win_q <= win_d;
      dtap_q <= dtap_d;
      single_q <= single_d;
      double_q <= double_d;
    end
  end
endmodule

/* File: verification/amte_properties.sv */
/*
  port assertions for the motion and tap event engine.
  assumes one clock domain and a synchronous active low reset.
*/
`timescale 1ns/100ps
module amte_properties (
  input  wire logic       mclk_in,
  input  wire logic       rst_n_in,
  input  wire logic [7:0] param_byte_6_in,
  input  wire logic [7:0] param_set_index_byte_in,
  input  wire logic       command_strobe_in,
  input  wire logic [7:0] command_handshake_reg_in,
  input  wire logic [7:0] feature_control_reg_in,
  input  wire logic [7:0] sensor_enable_reg_in,
  input  wire logic       free_running_sampling_in,
  input  wire logic       sample_ready_strobe_in,
  input  wire logic [7:0] event_status_reg_out,
  input  wire logic [7:0] motion_axis_mode_byte_out,
  input  wire logic       irq_pin_one_out,
  input  wire logic       irq_pin_two_out,
  input  wire logic       tap_single_out,
  input  wire logic       tap_double_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_set_one;
    command_strobe_in && command_handshake_reg_in == amte_pkg::CMD_CONFIGURE_MOTION
      && param_set_index_byte_in[7:4] == amte_pkg::PARAM_SET_ONE;
  endsequence
  sequence s_live_sample;
    $past(sample_ready_strobe_in) && $past(free_running_sampling_in);
  endsequence
  property p_mode_load; s_set_one |=> motion_axis_mode_byte_out == $past(param_byte_6_in); endproperty
  a_mode_load: assert property (p_mode_load) else $error("mode byte not loaded");
  property p_move_rise; $rose(event_status_reg_out[5]) |-> s_live_sample; endproperty
  a_move_rise: assert property (p_move_rise) else $error("move flag without sample");
  property p_still_rise; $rose(event_status_reg_out[6]) |-> s_live_sample; endproperty
  a_still_rise: assert property (p_still_rise) else $error("still flag without sample");
  property p_move_off;
    event_status_reg_out[5] |-> $past(feature_control_reg_in[1] && sensor_enable_reg_in[0]);
  endproperty
  a_move_off: assert property (p_move_off) else $error("move flag while off");
  property p_still_off; event_status_reg_out[6] |-> $past(feature_control_reg_in[2]); endproperty
  a_still_off: assert property (p_still_off) else $error("still flag while off");
  property p_sig_needs;
    event_status_reg_out[7] |-> ($past(feature_control_reg_in) & 8'h0e) == 8'h0e;
  endproperty
  a_sig_needs: assert property (p_sig_needs) else $error("sig flag without engines");
  property p_irq_cause; irq_pin_one_out || irq_pin_two_out |-> |event_status_reg_out[7:5]; endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without event");
  property p_irq_excl; !(irq_pin_one_out && irq_pin_two_out); endproperty
  a_irq_excl: assert property (p_irq_excl) else $error("both irq pins high");
  property p_low_zero; event_status_reg_out[4:0] == 5'h00; endproperty
  a_low_zero: assert property (p_low_zero) else $error("status low bits set");
  property p_tap_excl; !(tap_single_out && tap_double_out); endproperty
  a_tap_excl: assert property (p_tap_excl) else $error("both tap pulses high");
  property p_tap_pulse; tap_single_out || tap_double_out |=> !tap_single_out && !tap_double_out; endproperty
  a_tap_pulse: assert property (p_tap_pulse) else $error("tap pulse too long");
  property p_tap_src;
    tap_single_out || tap_double_out |-> $past(sample_ready_strobe_in, 2);
  endproperty
  a_tap_src: assert property (p_tap_src) else $error("tap without sample");
endmodule
bind amte_top amte_properties chk_u (.*);

/* File: verification/amte_host_model.sv */
/*
  host model: loads the two motion parameter sets and owns the sensor enables.
  assumes the device takes the bytes on the command strobe edge.
*/
`timescale 1ns/100ps
module amte_host_model (
  input  wire logic       mclk_in,
  output logic      [7:0] pb_out [8],
  output logic      [7:0] cmd_out,
  output logic            cmd_strobe_out,
  output logic      [7:0] sensor_out
);
  initial begin
    pb_out = '{default: 8'h00};
    cmd_out = 8'h00;
    cmd_strobe_out = 1'b0;
    sensor_out = 8'h00;
  end
  // no interlock in the device, so sensors go off here
  task automatic load(input logic [3:0] set, input logic [55:0] b);
    @(negedge mclk_in);
    sensor_out = 8'h00;
    for (int i = 0; i < 7; i++) pb_out[i] = b[8*i +: 8];
    pb_out[7] = {set, 4'h0};
    cmd_out = amte_pkg::CMD_CONFIGURE_MOTION;
    cmd_strobe_out = 1'b1;
    @(negedge mclk_in);
    cmd_strobe_out = 1'b0;
  endtask
  task automatic accel(input logic on);
    @(negedge mclk_in);
    sensor_out = {7'h00, on};
  endtask
endmodule

/* File: verification/testbench.sv */
/*
  testbench: random slope stream against a bench model of move and still detection.
  assumes the host model drives the configuration inputs.
*/
`timescale 1ns/100ps
module testbench;
  localparam int LIM = 2 << 5; // limit byte 2 in 1/1024 g units
  logic        mclk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic [7:0]  pb [8];
  logic [7:0]  cmd, sensor, status, mode, md, exs;
  logic [7:0]  fc = 8'h00, pc = 8'h00, pwa = 8'h04;
  logic [15:0] ax = 16'h0000, ay = 16'h0000, az = 16'h0000, pml = 16'h0004, ql = 16'hff00;
  logic        cmd_stb, irq1, irq2, tap1, tap2;
  logic        stb = 1'b0, frs = 1'b1;
  int          miscompares = 0, n_compared = 0;
  int          mw, sw, mc, sc, k, primed;
  int          prev [3], cur [3];
  amte_host_model host_u (.mclk_in, .pb_out(pb), .cmd_out(cmd), .cmd_strobe_out(cmd_stb),
    .sensor_out(sensor));
  amte_top dut_u (.mclk_in, .rst_n_in, .param_byte_0_in(pb[0]), .param_byte_1_in(pb[1]),
    .param_byte_2_in(pb[2]), .param_byte_3_in(pb[3]), .param_byte_4_in(pb[4]),
    .param_byte_5_in(pb[5]), .param_byte_6_in(pb[6]), .param_set_index_byte_in(pb[7]),
    .command_strobe_in(cmd_stb), .command_handshake_reg_in(cmd), .feature_control_reg_in(fc),
    .sensor_enable_reg_in(sensor), .pin_control_reg_in(pc), .free_running_sampling_in(frs),
    .sample_ready_strobe_in(stb), .accel_x_in(ax), .accel_y_in(ay), .accel_z_in(az),
    .tap_alpha_in(8'h08), .tap_gamma_in(8'h20), .peak_mag_limit_in(pml), .quiet_limit_in(ql),
    .peak_window_a_in(pwa), .tap_quiet_window_in(16'h0008), .double_tap_window_in(16'h0020),
    .event_status_reg_out(status), .motion_axis_mode_byte_out(mode), .irq_pin_one_out(irq1),
    .irq_pin_two_out(irq2), .tap_single_out(tap1), .tap_double_out(tap2));
  initial begin
    forever #12.5 mclk_in = ~mclk_in;
  end
  task automatic compare(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // slopes cluster on the limit to hit both sides often
  task automatic sample();
    int s, ma, mo, sa, so;
    if ($urandom_range(3) == 0) k = $urandom_range(3);
    for (int a = 0; a < 3; a++) cur[a] = prev[a] > 0 ? prev[a] - k * 32 - 1 : prev[a] + k * 32 + 1;
    cur[$urandom_range(2)] += $urandom_range(2) - 1;
    @(negedge mclk_in);
    {ax, ay, az, stb} = {cur[0][15:0], cur[1][15:0], cur[2][15:0], 1'b1};
    @(negedge mclk_in);
    stb = 1'b0;
    {ma, mo, sa, so} = {32'd1, 32'd0, 32'd1, 32'd0};
    for (int a = 0; a < 3; a++) begin
      s = cur[a] > prev[a] ? cur[a] - prev[a] : prev[a] - cur[a];
      if (md[a]) {ma, mo} = {ma & (s > LIM), mo | (s > LIM)};
      if (md[4 + a]) {sa, so} = {sa & (s < LIM), so | (s < LIM)};
    end
    if (primed) begin
      mc = (md[3] ? ma && md[2:0] != 3'h0 : mo) ? mc + 1 : 0;
      sc = (md[7] ? sa && md[6:4] != 3'h0 : so) ? sc + 1 : 0;
      exs = {1'b0, sc >= sw, mc >= mw, 5'h00};
    end
    primed = 1;
    prev = cur;
    @(posedge mclk_in);
    #1;
    compare(status, exs);
    compare({7'h00, irq1}, {7'h00, |exs && fc[6] && pc[3]});
    compare({7'h00, irq2}, {7'h00, |exs && !fc[6] && pc[4]});
  endtask
  initial begin
    void'($urandom(32'h2639));
    repeat (6) @(posedge mclk_in);
    @(negedge mclk_in);
    rst_n_in = 1'b1;
    compare(mode, amte_pkg::MODE_RESET);
    compare(status, 8'h00);
    for (int p = 0; p < 2; p++) begin
      {md, mw, sw, k} = {p ? 8'h3e : 8'hf3, 2 + p, 3 - p, 32'd0};
      {pml, ql, pwa} = {16'($urandom_range(8)), 16'($urandom_range(16'hffff, 16'h8000)), 8'h04};
      host_u.load(4'h1, {md, {6{8'h02}}});
      host_u.load(4'h2, {24'h000005, 16'h0002, sw[7:0], mw[7:0]});
      @(posedge mclk_in);
      #1;
      compare(mode, md);
      @(negedge mclk_in);
      {fc, pc} = p ? {8'h06, 8'h10} : {8'h46, 8'h18};
      host_u.accel(1'b1);
      {primed, mc, sc, exs} = {32'd0, 32'd0, 32'd0, 8'h00};
      prev = '{default: 0};
      repeat (150) sample();
      @(negedge mclk_in);
      {fc, frs} = p ? {fc, 1'b0} : 9'h001;
      repeat (2) @(posedge mclk_in);
      #1;
      compare(status, 8'h00);
      $display("motion pass %0d done", p);
    end
    end_of_test();
  end
  initial begin
    #100us;
    miscompares++;
    end_of_test();
  end
endmodule
